//--- core/mtp_pkg.sv
// Shared constants and types for the match timer PWM unit
package mtp_pkg;
    localparam int CNT_W      = 32;
    localparam int NUM_MATCH  = 7;
    localparam int NUM_PWM    = 6;
    localparam int NUM_CAP    = 2;
    localparam int NUM_EXT    = 4;
    localparam int NUM_DMA    = 2;
    // Index of the cycle-rate match register
    localparam int CYC_MATCH  = 0;
    // Edge select field: bit positions
    localparam int EDGE_RISE  = 0;
    localparam int EDGE_FALL  = 1;
    // External match output actions
    localparam logic [1:0] EXT_NONE = 2'h0;
    localparam logic [1:0] EXT_LOW  = 2'h1;
    localparam logic [1:0] EXT_HIGH = 2'h2;
    localparam logic [1:0] EXT_TOG  = 2'h3;
    localparam logic [31:0] CNT_RST = 32'h0;
    // Bit of the one-hot state that marks a halted counter
    localparam int HALT_BIT   = 2;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN  = 3'h2,
        ST_HALT = 3'h4
    } mtp_state_t;
endpackage

//--- core/mtp_pwm_unit.sv
// Timer/counter with prescaler, capture, match actions and PWM outputs
//
// Contract
// - 32-bit counter advanced through 32-bit prescaler
// - Count source is clock or capture input
// - Two captures copy count on input edge
// - Continuous match keeps counting, optional interrupt
// - Stop match halts counter, optional interrupt
// - Reset match zeroes counter, optional interrupt
// - Four match outputs: low, high, toggle, none
// - Two matches can issue DMA requests
// - Seven matches give six single/three double outputs
// - Cycle-rate match resets count, ends PWM cycle
// - Single-edge outputs rise at cycle start
// - Single-edge output uses one own match
// - Double-edge output uses rise and fall matches
// - All outputs share one repetition period
// - Period and width are any whole count
// - Released match values apply at cycle boundary
// - Without PWM mode, plain timer/counter
`timescale 1ns/1ns
module mtp_pwm_unit #(
    parameter int CW = mtp_pkg::CNT_W,
    parameter int NM = mtp_pkg::NUM_MATCH,
    parameter int NP = mtp_pkg::NUM_PWM
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                count_en,
    input  wire logic                count_reset,
    input  wire logic                pwm_mode,
    input  wire logic                count_src_sel,
    input  wire logic                count_cap_sel,
    input  wire logic [1:0]          count_edge,
    input  wire logic [CW-1:0]       prescale_limit,
    input  wire logic [1:0]          cap_in,
    input  wire logic [1:0][1:0]     cap_edge,
    input  wire logic [1:0]          cap_irq_en,
    input  wire logic [NM-1:0][CW-1:0] match_val,
    input  wire logic [NM-1:0]       release_req,
    input  wire logic [NM-1:0]       match_irq_en,
    input  wire logic [NM-1:0]       match_stop_en,
    input  wire logic [NM-1:0]       match_reset_en,
    input  wire logic [3:0][1:0]     ext_ctrl,
    input  wire logic [NP-1:0]       dbl_edge_sel,
    input  wire logic [NP-1:0]       pwm_en,
    output logic      [CW-1:0]       count_val,
    output logic      [CW-1:0]       prescale_val,
    output logic      [1:0][CW-1:0]  cap_val,
    output logic      [NM-1:0]       match_irq,
    output logic      [1:0]          cap_irq,
    output logic      [1:0]          dma_req,
    output logic      [3:0]          ext_match,
    output logic      [NP-1:0]       pwm_out,
    output logic      [NM-1:0]       release_pending,
    output logic                     halted
);

    function automatic logic edge_hit(input logic p, input logic c, input logic [1:0] m);
        edge_hit = (m[mtp_pkg::EDGE_RISE] & ~p & c) | (m[mtp_pkg::EDGE_FALL] & p & ~c);
    endfunction

    mtp_pkg::mtp_state_t    state_r, state_nxt;
    logic [CW-1:0]          tc_r, tc_nxt, pc_r, pc_nxt;
    logic [1:0]             cap_prev_r;
    logic [1:0]             cap_ev;
    logic                   src_ev, tick, do_reset, do_stop, apply;
    logic [NM-1:0]          hit, reset_mask;
    logic [NM-1:0][CW-1:0]  shadow_r, shadow_nxt, act_r, act_nxt;
    logic [NM-1:0]          pend_r, pend_nxt;
    logic [1:0][CW-1:0]     cap_r, cap_nxt;
    logic [NM-1:0]          mirq_r, mirq_nxt;
    logic [1:0]             cirq_r, cirq_nxt, dma_r, dma_nxt;
    logic [3:0]             ext_r, ext_nxt;
    logic [NP-1:0]          pwm_r, pwm_nxt;
    logic                   pset, pclr;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Count source and match detection
    always_comb begin
        for (int i = 0; i < mtp_pkg::NUM_CAP; i++) begin
            cap_ev[i] = edge_hit(cap_prev_r[i], cap_in[i], cap_edge[i]);
        end
        src_ev = count_src_sel ?
                 edge_hit(cap_prev_r[count_cap_sel], cap_in[count_cap_sel], count_edge) :
                 1'b1;
        tick = (state_r == mtp_pkg::ST_RUN) && src_ev && (pc_r == prescale_limit);
        for (int i = 0; i < NM; i++) begin
            hit[i] = tick && (tc_r == act_r[i]);
        end
        // Cycle-rate match always restarts the count in PWM mode
        reset_mask = match_reset_en;
        reset_mask[mtp_pkg::CYC_MATCH] = match_reset_en[mtp_pkg::CYC_MATCH] | pwm_mode;
        do_reset = |(hit & reset_mask);
        do_stop  = |(hit & match_stop_en);
        apply    = count_reset || (tick && hit[mtp_pkg::CYC_MATCH] && do_reset);
    end

    // Counter, prescaler and run state
    always_comb begin
        state_nxt = state_r;
        pc_nxt    = pc_r;
        tc_nxt    = tc_r;
        case (state_r)
            mtp_pkg::ST_IDLE: begin
                if (count_en) begin
                    state_nxt = mtp_pkg::ST_RUN;
                end
            end
            mtp_pkg::ST_RUN: begin
                if (!count_en) begin
                    state_nxt = mtp_pkg::ST_IDLE;
                end else if (do_stop && !count_reset) begin
                    state_nxt = mtp_pkg::ST_HALT;
                end
            end
            mtp_pkg::ST_HALT: begin
                if (!count_en) begin
                    state_nxt = mtp_pkg::ST_IDLE;
                end
            end
            default: state_nxt = mtp_pkg::ST_IDLE;
        endcase
        if ((state_r == mtp_pkg::ST_RUN) && src_ev) begin
            pc_nxt = (pc_r == prescale_limit) ? mtp_pkg::CNT_RST[CW-1:0] : pc_r + 1'b1;
        end
        if (tick) begin
            if (do_reset) begin
                tc_nxt = mtp_pkg::CNT_RST[CW-1:0];
            end else if (!do_stop) begin
                tc_nxt = tc_r + 1'b1;
            end
        end
        if (count_reset) begin
            pc_nxt = mtp_pkg::CNT_RST[CW-1:0];
            tc_nxt = mtp_pkg::CNT_RST[CW-1:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r    <= mtp_pkg::ST_IDLE;
            pc_r       <= '0;
            tc_r       <= '0;
            cap_prev_r <= '0;
        end else begin
            state_r    <= state_nxt;
            pc_r       <= pc_nxt;
            tc_r       <= tc_nxt;
            cap_prev_r <= cap_in;
        end
    end

    // Match value shadowing; a release in the apply cycle stays pending
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            shadow_nxt[i] = release_req[i] ? match_val[i] : shadow_r[i];
            if (!pwm_mode) begin
                act_nxt[i]  = match_val[i];
                pend_nxt[i] = 1'b0;
            end else begin
                act_nxt[i]  = (apply && pend_r[i]) ? shadow_r[i] : act_r[i];
                pend_nxt[i] = release_req[i] | (pend_r[i] & ~apply);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_r <= '0;
            act_r    <= '0;
            pend_r   <= '0;
        end else begin
            shadow_r <= shadow_nxt;
            act_r    <= act_nxt;
            pend_r   <= pend_nxt;
        end
    end

    // Events, captures, match pins and PWM pins
    always_comb begin
        pset = 1'b0;
        pclr = 1'b0;
        mirq_nxt = hit & match_irq_en;
        dma_nxt  = hit[mtp_pkg::NUM_DMA-1:0];
        for (int i = 0; i < mtp_pkg::NUM_CAP; i++) begin
            cirq_nxt[i] = cap_ev[i] & cap_irq_en[i];
            cap_nxt[i]  = cap_ev[i] ? tc_r : cap_r[i];
        end
        for (int i = 0; i < mtp_pkg::NUM_EXT; i++) begin
            ext_nxt[i] = ext_r[i];
            if (hit[i]) begin
                case (ext_ctrl[i])
                    mtp_pkg::EXT_LOW:  ext_nxt[i] = 1'b0;
                    mtp_pkg::EXT_HIGH: ext_nxt[i] = 1'b1;
                    mtp_pkg::EXT_TOG:  ext_nxt[i] = ~ext_r[i];
                    default:           ext_nxt[i] = ext_r[i];
                endcase
            end
        end
        for (int k = 0; k < NP; k++) begin
            // Output k uses match k+1; double edge also uses match k
            if (k > 0 && dbl_edge_sel[k]) begin
                pset = hit[k];
            end else begin
                pset = hit[mtp_pkg::CYC_MATCH];
            end
            pclr = hit[k+1];
            // Falling wins so a shared count never glitches
            if (!pwm_mode || !pwm_en[k]) begin
                pwm_nxt[k] = 1'b0;
            end else if (pclr) begin
                pwm_nxt[k] = 1'b0;
            end else if (pset) begin
                pwm_nxt[k] = 1'b1;
            end else begin
                pwm_nxt[k] = pwm_r[k];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mirq_r <= '0;
            cirq_r <= '0;
            dma_r  <= '0;
            cap_r  <= '0;
            ext_r  <= '0;
            pwm_r  <= '0;
        end else begin
            mirq_r <= mirq_nxt;
            cirq_r <= cirq_nxt;
            dma_r  <= dma_nxt;
            cap_r  <= cap_nxt;
            ext_r  <= ext_nxt;
            pwm_r  <= pwm_nxt;
        end
    end

    assign count_val       = tc_r;
    assign prescale_val    = pc_r;
    assign cap_val         = cap_r;
    assign match_irq       = mirq_r;
    assign cap_irq         = cirq_r;
    assign dma_req         = dma_r;
    assign ext_match       = ext_r;
    assign pwm_out         = pwm_r;
    assign release_pending = pend_r;
    assign halted          = state_r[mtp_pkg::HALT_BIT];

    sequence s_stop_hit;
        state_r == mtp_pkg::ST_RUN && count_en && do_stop && !count_reset;
    endsequence

    sequence s_cycle_end;
        pwm_mode && tick && hit[mtp_pkg::CYC_MATCH] && !count_reset;
    endsequence

    a_prescale_wrap: assert property (
        (tick && !count_reset) |=> pc_r == '0
            && ($past(tc_r) != tc_r || $past(do_reset) || $past(do_stop)))
        else $error("prescaler did not wrap or count did not move");
    a_count_step: assert property (
        (tick && !do_reset && !do_stop && !count_reset) |=> tc_r == $past(tc_r) + 1'b1)
        else $error("count did not advance by one");
    a_reset_match: assert property (
        (tick && do_reset && !count_reset) |=> tc_r == '0)
        else $error("reset match did not zero count");
    a_stop_halt: assert property (
        // Reset on the same tick still zeroes the count while halting
        s_stop_hit ##1 count_en |-> halted
            && ($past(do_reset) ? tc_r == '0 : tc_r == $past(tc_r)))
        else $error("stop match did not halt count");
    a_capture_copy: assert property (
        cap_ev[0] |=> cap_val[0] == $past(tc_r) && cap_irq[0] == $past(cap_irq_en[0]))
        else $error("capture did not copy count");
    a_match_irq: assert property (
        (|(hit & match_irq_en)) |=> match_irq == $past(hit & match_irq_en))
        else $error("match interrupt missing");
    a_cycle_restart: assert property (
        s_cycle_end |=> tc_r == '0)
        else $error("cycle-rate match did not restart count");
    a_single_rise: assert property (
        s_cycle_end ##0 (pwm_en[0] && !hit[1]) |=> pwm_out[0])
        else $error("single-edge output did not rise at cycle start");
    a_release_hold: assert property (
        (pwm_mode && !apply) |=> act_r == $past(act_r))
        else $error("match value changed inside a cycle");
    a_dbl_resolve: assert property (
        (pwm_mode && pwm_en[1] && dbl_edge_sel[1] && hit[1] && hit[2]) |=> !pwm_out[1])
        else $error("coinciding edges did not resolve low");
    a_ext_toggle: assert property (
        (hit[1] && ext_ctrl[1] == mtp_pkg::EXT_TOG) |=> ext_match[1] != $past(ext_match[1]))
        else $error("match output did not toggle");
    a_dma_pulse: assert property (
        (|hit[mtp_pkg::NUM_DMA-1:0]) |=> dma_req == $past(hit[mtp_pkg::NUM_DMA-1:0]))
        else $error("timed transfer request missing");
    a_single_fall: assert property (
        (pwm_mode && pwm_en[0] && hit[1]) |=> !pwm_out[0])
        else $error("single-edge output did not fall on its match");

endmodule

//--- verification/mtp_load_model.sv
// Load model on the PWM pins: measures high time and period of one pin
`timescale 1ns/1ns
module mtp_load_model (
    input  wire logic       clk,
    input  wire logic [5:0] pins,
    input  wire logic [2:0] sel,
    output int              hi_len = 0,
    output int              per_len = 0,
    output int              rises = 0
);
    // A motor driver input draws no current, so the pins are only observed
    logic prev = 1'b0;
    int   hi_cnt = 0;
    int   per_cnt = 0;
    always @(posedge clk) begin
        prev <= pins[sel];
        if (pins[sel] === 1'b1 && prev !== 1'b1) begin
            hi_len <= hi_cnt;
            per_len <= per_cnt;
            hi_cnt <= 1;
            per_cnt <= 1;
            rises <= rises + 1;
        end else begin
            per_cnt <= per_cnt + 1;
            hi_cnt <= hi_cnt + ((pins[sel] === 1'b1) ? 1 : 0);
        end
    end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the match timer PWM unit
`timescale 1ns/1ns
module testbench;
    logic             clk, rst, count_en, count_reset, pwm_mode, count_src_sel;
    logic             count_cap_sel, halted;
    logic [1:0]       count_edge, cap_in, cap_irq_en, cap_irq, dma_req;
    logic [31:0]      prescale_limit, count_val, prescale_val;
    logic [1:0][1:0]  cap_edge;
    logic [6:0][31:0] match_val;
    logic [6:0]       release_req, match_irq_en, match_stop_en, match_reset_en;
    logic [6:0]       match_irq, release_pending;
    logic [3:0][1:0]  ext_ctrl;
    logic [5:0]       dbl_edge_sel, pwm_en, pwm_out;
    logic [1:0][31:0] cap_val;
    logic [3:0]       ext_match;
    logic [2:0]       sel;
    int               fails = 0, tests_run = 0, hi_len, per_len, rises;
    int               irq2_n = 0, irq3_n = 0, dma0_n = 0, dma1_n = 0, capi_n = 0;

    mtp_pwm_unit i_mtp_pwm_unit (.clk, .rst, .count_en, .count_reset, .pwm_mode,
        .count_src_sel, .count_cap_sel, .count_edge, .prescale_limit, .cap_in, .cap_edge,
        .cap_irq_en, .match_val, .release_req, .match_irq_en, .match_stop_en,
        .match_reset_en, .ext_ctrl, .dbl_edge_sel, .pwm_en, .count_val, .prescale_val,
        .cap_val, .match_irq, .cap_irq, .dma_req, .ext_match, .pwm_out, .release_pending,
        .halted);
    mtp_load_model i_mtp_load_model (.clk, .pins(pwm_out), .sel, .hi_len, .per_len, .rises);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        irq2_n += (match_irq[2] === 1'b1);
        irq3_n += (match_irq[3] === 1'b1);
        dma0_n += (dma_req[0] === 1'b1);
        dma1_n += (dma_req[1] === 1'b1);
        capi_n += (cap_irq[0] === 1'b1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask

    // Release every match, then hold the count reset so the shadows apply
    task automatic setup(input logic pm, input logic [31:0] lim);
        count_en = 1'b0;
        pwm_mode = pm;
        prescale_limit = lim;
        count_reset = 1'b1;
        release_req = 7'h7f;
        tick(1);
        release_req = 7'h00;
        tick(2);
        count_reset = 1'b0;
        count_en = 1'b1;
    endtask

    task automatic wait_rises(input int n);
        int r;
        r = rises + n;
        for (int i = 0; i < 300 && rises < r; i++)
            tick(1);
        check(rises >= r, 1'b1);
    endtask

    task automatic t_presc;
        logic [31:0] c;
        setup(1'b0, 32'h2);
        tick(5);
        c = count_val;
        tick(3);
        check(count_val, c + 32'h1);
        tick(6);
        check(count_val, c + 32'h3);
        check(prescale_val, 32'h1);
    endtask

    task automatic t_stop;
        int n2;
        int n3;
        n2 = irq2_n;
        n3 = irq3_n;
        match_val[2] = 32'h5;
        match_val[3] = 32'h2;
        match_stop_en = 7'h04;
        match_irq_en = 7'h0c;
        setup(1'b0, 32'h0);
        for (int i = 0; i < 30 && halted !== 1'b1; i++)
            tick(1);
        tick(3);
        check(count_val, 32'h5);
        check(halted, 1'b1);
        check(irq2_n - n2, 1);
        check(irq3_n - n3, 1);
        match_stop_en = 7'h00;
        match_irq_en = 7'h00;
    endtask

    task automatic t_ext;
        logic [4:0][1:0] code;
        int d;
        code = {mtp_pkg::EXT_TOG, mtp_pkg::EXT_NONE, mtp_pkg::EXT_TOG, mtp_pkg::EXT_LOW,
                mtp_pkg::EXT_HIGH};
        d = dma1_n;
        match_val[1] = 32'h2;
        for (int i = 0; i < 5; i++) begin
            ext_ctrl[1] = code[i];
            setup(1'b0, 32'h0);
            tick(8);
            check(ext_match[1], 5'b01101 >> i & 1);
        end
        check(dma1_n - d, 5);
    endtask

    // Counter clocked by edges of the second capture input
    task automatic t_cap;
        int n;
        n = capi_n;
        count_src_sel = 1'b1;
        count_cap_sel = 1'b1;
        setup(1'b0, 32'h0);
        // Entering run takes a cycle; an earlier count edge would be lost
        tick(1);
        repeat (3) begin
            cap_in[1] = 1'b1;
            tick(3);
            cap_in[1] = 1'b0;
            tick(3);
        end
        check(count_val, 32'h3);
        cap_in[0] = 1'b1;
        tick(4);
        check(cap_val[0], 32'h3);
        check(capi_n - n, 1);
        count_src_sel = 1'b0;
    endtask

    // Reset match outside PWM mode restarts the count every five ticks
    task automatic t_rst;
        match_val[4] = 32'h4;
        match_reset_en = 7'h10;
        setup(1'b0, 32'h0);
        tick(12);
        check(count_val, 32'h1);
        match_reset_en = 7'h00;
    endtask

    task automatic t_single;
        int d;
        sel = 3'h0;
        match_val[0] = 32'h3;
        match_val[1] = 32'h1;
        match_reset_en = 7'h01;
        pwm_en = 6'h01;
        setup(1'b1, 32'h0);
        check(release_pending, 7'h00);
        d = dma0_n;
        wait_rises(2);
        check(per_len, 4);
        check(hi_len, 2);
        check(dma0_n - d, 2);
        match_val[1] = 32'h2;
        release_req = 7'h02;
        tick(1);
        release_req = 7'h00;
        check(release_pending[1], 1'b1);
        wait_rises(3);
        check(hi_len, 3);
    endtask

    task automatic t_dbl;
        int r;
        sel = 3'h1;
        match_val[0] = 32'h7;
        match_val[1] = 32'h2;
        match_val[2] = 32'h5;
        dbl_edge_sel = 6'h02;
        pwm_en = 6'h02;
        setup(1'b1, 32'h0);
        wait_rises(2);
        check(per_len, 8);
        check(hi_len, 3);
        match_val[1] = 32'h5;
        match_val[2] = 32'h2;
        setup(1'b1, 32'h0);
        wait_rises(2);
        check(hi_len, 5);
        match_val[2] = 32'h5;
        setup(1'b1, 32'h0);
        tick(10);
        r = rises;
        tick(16);
        check(rises - r, 0);
        check(pwm_out[1], 1'b0);
    endtask

    task automatic final_report;
        $display("Comparisons: %0d, mismatches: %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        final_report;
    end

    initial begin
        rst = 1'b1;
        {count_en, count_reset, pwm_mode, count_src_sel, count_cap_sel} = 5'h00;
        {count_edge, cap_in, cap_edge, cap_irq_en} = 10'h000;
        count_edge = 2'h1;
        cap_edge[0] = 2'h1;
        cap_irq_en = 2'h1;
        prescale_limit = 32'h0;
        match_val = '0;
        {release_req, match_irq_en, match_stop_en, match_reset_en} = 28'h0;
        ext_ctrl = 8'h00;
        {dbl_edge_sel, pwm_en} = 12'h000;
        sel = 3'h0;
        repeat (4) @(posedge clk);
        #5 rst = 1'b0;
        tick(1);
        check(count_val, 32'h0);
        check({pwm_out, halted}, 7'h00);
        t_presc;
        t_stop;
        t_ext;
        t_cap;
        t_rst;
        t_single;
        t_dbl;
        final_report;
    end
endmodule
